// >>> wdc_pkg.sv
// Package: register map, reset values, sequence words and timing counts for the watchdog
package wdc_pkg;
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] ADDR_CNT_HIGH = 3'h2;
  localparam logic [2:0] ADDR_CNT_LOW = 3'h3;
  localparam logic [2:0] ADDR_LIM_HIGH = 3'h4;
  localparam logic [2:0] ADDR_LIM_LOW = 3'h5;
  localparam logic [2:0] ADDR_EARLY_HIGH = 3'h6;
  localparam logic [2:0] ADDR_EARLY_LOW = 3'h7;
  localparam int CTRL1_EN_BIT = 7;
  localparam int CTRL1_UPDATE_BIT = 5;
  localparam int CTRL2_WIN_BIT = 7;
  localparam int CTRL2_DIVIDE_BY_256_ON_BIT = 4;
  localparam int CTRL2_CLK_LSB = 0;
  localparam logic [7:0] CTRL1_RESET = 8'h80;
  localparam logic [7:0] CTRL2_RESET = 8'h01;
  localparam logic [15:0] LIMIT_RESET = 16'h0004;
  localparam logic [15:0] EARLY_RESET = 16'h0000;
  localparam logic [15:0] REFRESH_FIRST = 16'h02A6;
  localparam logic [15:0] REFRESH_SECOND = 16'h80B4;
  localparam logic [15:0] UNLOCK_FIRST = 16'h20C5;
  localparam logic [15:0] UNLOCK_SECOND = 16'h28D9;
  localparam int SEQ_GAP_CYCLES = 16;
  localparam int CFG_WINDOW_CYCLES = 128;
  localparam int PRESCALE_DIV = 256;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_LPO = 2'h1;
  localparam logic [1:0] CLK_INT32K = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_HIGH1, SEQ_WAIT2, SEQ_HIGH2} wdc_seq_t;
  typedef enum logic [1:0] {KIND_NONE, KIND_REFRESH, KIND_UNLOCK} wdc_kind_t;
endpackage : wdc_pkg

// >>> wdc_tick_gen.sv
// Module: reference clock select, synchronise, edge detect and optional divide by 256
`timescale 1ns/1ns
`default_nettype none
module wdc_tick_gen (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [1:0] clkSel,
  input wire logic divOn,
  input wire logic lpoClk,
  input wire logic int32kClk,
  input wire logic extClk,
  output logic tick
);
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] prevB;
  logic [7:0] divCnt;
  logic next_tick;
  logic [7:0] next_divCnt;
  logic edgeSel;
  // Source select and prescale
  always_comb begin
    edgeSel = 1'b0;
    case (clkSel)
      wdc_pkg::CLK_BUS: edgeSel = 1'b1;
      wdc_pkg::CLK_LPO: edgeSel = syncB[0] & ~prevB[0];
      wdc_pkg::CLK_INT32K: edgeSel = syncB[1] & ~prevB[1];
      wdc_pkg::CLK_EXT: edgeSel = syncB[2] & ~prevB[2];
      default: edgeSel = 1'b0;
    endcase
    next_divCnt = divCnt;
    next_tick = 1'b0;
    if (edgeSel) begin
      if (divOn) begin
        next_divCnt = divCnt + 8'h01;
        next_tick = (divCnt == 8'(wdc_pkg::PRESCALE_DIV - 1));
      end else begin
        next_tick = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      // Sync chain keeps tracking the pins so release brings no false edge
      syncA <= {extClk, int32kClk, lpoClk};
      syncB <= syncA;
      prevB <= syncB;
      divCnt <= 8'h00;
      tick <= 1'b0;
    end else if (clkEn) begin
      syncA <= {extClk, int32kClk, lpoClk};
      syncB <= syncA;
      prevB <= syncB;
      divCnt <= next_divCnt;
      tick <= next_tick;
    end
  end
endmodule : wdc_tick_gen
`default_nettype wire

// >>> wdc_watchdog.sv
// Module: windowed watchdog counter with write-once configuration and service sequences
`timescale 1ns/1ns
`default_nettype none
module wdc_watchdog (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic lowPowerOsc1khz,
  input wire logic int32kClk,
  input wire logic extClk,
  output logic forceReset,
  output logic configOpen
);
  // Active configuration
  logic [7:0] ctrlOne;
  logic [7:0] ctrlTwo;
  logic [15:0] limit;
  logic [15:0] early;
  // Pending configuration and written marks
  logic [7:0] pendOne;
  logic [7:0] pendTwo;
  logic [15:0] pendLimit;
  logic [15:0] pendEarly;
  logic [7:0] written;
  logic [7:0] openCnt;
  logic [15:0] count;
  logic [7:0] seqHigh;
  logic [4:0] gapCnt;
  wdc_pkg::wdc_seq_t seqState;
  wdc_pkg::wdc_kind_t seqKind;
  logic tick;
  logic [7:0] next_ctrlOne;
  logic [7:0] next_ctrlTwo;
  logic [15:0] next_limit;
  logic [15:0] next_early;
  logic [7:0] next_pendOne;
  logic [7:0] next_pendTwo;
  logic [15:0] next_pendLimit;
  logic [15:0] next_pendEarly;
  logic [7:0] next_written;
  logic [7:0] next_openCnt;
  logic [15:0] next_count;
  logic [7:0] next_seqHigh;
  logic [4:0] next_gapCnt;
  wdc_pkg::wdc_seq_t next_seqState;
  wdc_pkg::wdc_kind_t next_seqKind;
  logic [7:0] next_regRdData;
  logic next_forceReset;
  logic next_configOpen;
  logic cntWrite;
  logic [15:0] word;
  logic wordDone;
  logic badWrite;
  logic windowOn;
  logic allWritten;

  initial begin
    if (wdc_pkg::CFG_WINDOW_CYCLES > 255 || wdc_pkg::SEQ_GAP_CYCLES > 31) begin
      $error("wdc_watchdog: counters too narrow");
    end
  end

  function automatic logic isCfgAddr(input logic [2:0] a);
    isCfgAddr = (a != wdc_pkg::ADDR_CNT_HIGH) && (a != wdc_pkg::ADDR_CNT_LOW);
  endfunction : isCfgAddr

  wdc_tick_gen u_tick (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .clkSel(ctrlTwo[wdc_pkg::CTRL2_CLK_LSB +: 2]),
    .divOn(ctrlTwo[wdc_pkg::CTRL2_DIVIDE_BY_256_ON_BIT]),
    .lpoClk(lowPowerOsc1khz),
    .int32kClk(int32kClk),
    .extClk(extClk),
    .tick(tick)
  );

  assign cntWrite = regWr && !isCfgAddr(regAddr);
  assign word = {seqHigh, regWrData};
  assign windowOn = ctrlTwo[wdc_pkg::CTRL2_WIN_BIT];

  // Sequence checking, configuration and counter
  always_comb begin
    next_ctrlOne = ctrlOne;
    next_ctrlTwo = ctrlTwo;
    next_limit = limit;
    next_early = early;
    next_pendOne = pendOne;
    next_pendTwo = pendTwo;
    next_pendLimit = pendLimit;
    next_pendEarly = pendEarly;
    next_written = written;
    next_openCnt = (openCnt != 8'h00) ? openCnt - 8'h01 : 8'h00;
    next_seqHigh = seqHigh;
    next_gapCnt = (gapCnt != 5'h00) ? gapCnt - 5'h01 : 5'h00;
    next_seqState = seqState;
    next_seqKind = seqKind;
    wordDone = 1'b0;
    badWrite = 1'b0;
    next_count = count;
    if (ctrlOne[wdc_pkg::CTRL1_EN_BIT] && tick) begin
      next_count = count + 16'h0001;
    end
    // Byte pairing of counter writes
    if (cntWrite) begin
      if (regAddr == wdc_pkg::ADDR_CNT_HIGH && seqState != wdc_pkg::SEQ_HIGH1
          && seqState != wdc_pkg::SEQ_HIGH2) begin
        next_seqHigh = regWrData;
        next_seqState = (seqState == wdc_pkg::SEQ_WAIT2) ? wdc_pkg::SEQ_HIGH2 : wdc_pkg::SEQ_HIGH1;
      end else if (regAddr == wdc_pkg::ADDR_CNT_LOW && seqState == wdc_pkg::SEQ_HIGH1) begin
        if (word == wdc_pkg::REFRESH_FIRST) begin
          next_seqKind = wdc_pkg::KIND_REFRESH;
          next_seqState = wdc_pkg::SEQ_WAIT2;
          next_gapCnt = 5'(wdc_pkg::SEQ_GAP_CYCLES);
        end else if (word == wdc_pkg::UNLOCK_FIRST && openCnt == 8'h00) begin
          next_seqKind = wdc_pkg::KIND_UNLOCK;
          next_seqState = wdc_pkg::SEQ_WAIT2;
          next_gapCnt = 5'(wdc_pkg::SEQ_GAP_CYCLES);
        end else begin
          badWrite = 1'b1;
        end
      end else if (regAddr == wdc_pkg::ADDR_CNT_LOW && seqState == wdc_pkg::SEQ_HIGH2) begin
        wordDone = 1'b1;
        next_seqState = wdc_pkg::SEQ_IDLE;
        next_seqKind = wdc_pkg::KIND_NONE;
        if (seqKind == wdc_pkg::KIND_REFRESH && word == wdc_pkg::REFRESH_SECOND) begin
          if (windowOn && count < early) begin
            badWrite = 1'b1;
          end else begin
            next_count = 16'h0000;
          end
        end else if (seqKind == wdc_pkg::KIND_UNLOCK && word == wdc_pkg::UNLOCK_SECOND
                     && ctrlOne[wdc_pkg::CTRL1_UPDATE_BIT]) begin
          next_openCnt = 8'(wdc_pkg::CFG_WINDOW_CYCLES);
          next_written = 8'h00;
        end else begin
          badWrite = 1'b1;
        end
      end else begin
        badWrite = 1'b1;
      end
    end
    if (!wordDone && (seqState == wdc_pkg::SEQ_WAIT2 || seqState == wdc_pkg::SEQ_HIGH2)
        && gapCnt == 5'h00 && !(cntWrite && regAddr == wdc_pkg::ADDR_CNT_HIGH)) begin
      badWrite = 1'b1;
    end
    // Write-once configuration inside the open period
    if (regWr && isCfgAddr(regAddr) && openCnt != 8'h00 && !written[regAddr]) begin
      next_written[regAddr] = 1'b1;
      case (regAddr)
        wdc_pkg::ADDR_CTRL_ONE: next_pendOne = regWrData;
        wdc_pkg::ADDR_CTRL_TWO: next_pendTwo = regWrData & 8'h93;
        wdc_pkg::ADDR_LIM_HIGH: next_pendLimit[15:8] = regWrData;
        wdc_pkg::ADDR_LIM_LOW: next_pendLimit[7:0] = regWrData;
        wdc_pkg::ADDR_EARLY_HIGH: next_pendEarly[15:8] = regWrData;
        wdc_pkg::ADDR_EARLY_LOW: next_pendEarly[7:0] = regWrData;
        default: next_pendOne = pendOne;
      endcase
    end
    allWritten = next_written[0] && next_written[1] && next_written[4] && next_written[5]
                 && (!next_pendTwo[wdc_pkg::CTRL2_WIN_BIT] || (next_written[6] && next_written[7]));
    if (allWritten && (written != next_written)) begin
      next_ctrlOne = next_pendOne;
      next_ctrlTwo = next_pendTwo;
      next_limit = next_pendLimit;
      next_early = next_pendEarly;
      if (!next_pendOne[wdc_pkg::CTRL1_UPDATE_BIT]) begin
        next_openCnt = 8'h00;
      end
    end
    next_forceReset = badWrite || (ctrlOne[wdc_pkg::CTRL1_EN_BIT] && count >= limit);
    next_configOpen = next_openCnt != 8'h00;
  end

  // Register read port, one cycle latency
  always_comb begin
    next_regRdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        wdc_pkg::ADDR_CTRL_ONE: next_regRdData = ctrlOne;
        wdc_pkg::ADDR_CTRL_TWO: next_regRdData = ctrlTwo;
        wdc_pkg::ADDR_CNT_HIGH: next_regRdData = count[15:8];
        wdc_pkg::ADDR_CNT_LOW: next_regRdData = count[7:0];
        wdc_pkg::ADDR_LIM_HIGH: next_regRdData = limit[15:8];
        wdc_pkg::ADDR_LIM_LOW: next_regRdData = limit[7:0];
        wdc_pkg::ADDR_EARLY_HIGH: next_regRdData = early[15:8];
        wdc_pkg::ADDR_EARLY_LOW: next_regRdData = early[7:0];
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlOne <= wdc_pkg::CTRL1_RESET;
      ctrlTwo <= wdc_pkg::CTRL2_RESET;
      limit <= wdc_pkg::LIMIT_RESET;
      early <= wdc_pkg::EARLY_RESET;
      pendOne <= wdc_pkg::CTRL1_RESET;
      pendTwo <= wdc_pkg::CTRL2_RESET;
      pendLimit <= wdc_pkg::LIMIT_RESET;
      pendEarly <= wdc_pkg::EARLY_RESET;
      written <= 8'h00;
      openCnt <= 8'(wdc_pkg::CFG_WINDOW_CYCLES);
      count <= 16'h0000;
      seqHigh <= 8'h00;
      gapCnt <= 5'h00;
      seqState <= wdc_pkg::SEQ_IDLE;
      seqKind <= wdc_pkg::KIND_NONE;
      regRdData <= 8'h00;
      forceReset <= 1'b0;
      configOpen <= 1'b1;
    end else if (clkEn) begin
      ctrlOne <= next_ctrlOne;
      ctrlTwo <= next_ctrlTwo;
      limit <= next_limit;
      early <= next_early;
      pendOne <= next_pendOne;
      pendTwo <= next_pendTwo;
      pendLimit <= next_pendLimit;
      pendEarly <= next_pendEarly;
      written <= next_written;
      openCnt <= next_openCnt;
      count <= next_count;
      seqHigh <= next_seqHigh;
      gapCnt <= next_gapCnt;
      seqState <= next_seqState;
      seqKind <= next_seqKind;
      regRdData <= next_regRdData;
      forceReset <= next_forceReset;
      configOpen <= next_configOpen;
    end
  end

  // Checks
  sequence refreshSecond_s;
    clkEn && cntWrite && regAddr == wdc_pkg::ADDR_CNT_LOW && seqState == wdc_pkg::SEQ_HIGH2
      && seqKind == wdc_pkg::KIND_REFRESH && word == wdc_pkg::REFRESH_SECOND;
  endsequence
  sequence inWindow_s;
    !(windowOn && count < early);
  endsequence
  sequence tooEarly_s;
    windowOn && count < early;
  endsequence

  refresh_clears_a: assert property (@(posedge mclk) disable iff (reset)
    refreshSecond_s and inWindow_s |=> count == 16'h0000 || count == 16'h0001)
    else $error("refresh did not clear counter");
  early_refresh_a: assert property (@(posedge mclk) disable iff (reset)
    refreshSecond_s and tooEarly_s |=> forceReset)
    else $error("early refresh not punished");
  frozen_count_a: assert property (@(posedge mclk) disable iff (reset)
    !clkEn |=> $stable(count))
    else $error("counter moved while frozen");
  config_hold_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && !written[0] && !(regWr && regAddr == wdc_pkg::ADDR_CTRL_ONE) |=> $stable(ctrlTwo) && $stable(limit))
    else $error("configuration applied before all writes");
  unlock_opens_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && cntWrite && regAddr == wdc_pkg::ADDR_CNT_LOW && seqState == wdc_pkg::SEQ_HIGH2
      && seqKind == wdc_pkg::KIND_UNLOCK && word == wdc_pkg::UNLOCK_SECOND
      && ctrlOne[wdc_pkg::CTRL1_UPDATE_BIT] |=> configOpen)
    else $error("unlock did not open configuration");
  timeout_reset_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && ctrlOne[wdc_pkg::CTRL1_EN_BIT] && count >= limit |=> forceReset)
    else $error("timeout missed");
  bad_write_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && cntWrite && regAddr == wdc_pkg::ADDR_CNT_LOW && seqState == wdc_pkg::SEQ_IDLE |=> forceReset)
    else $error("illegal counter write not punished");
  read_live_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && regRd && regAddr == wdc_pkg::ADDR_CNT_LOW |=> regRdData == $past(count[7:0]))
    else $error("counter read wrong");
  gap_limit_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && seqState == wdc_pkg::SEQ_WAIT2 && gapCnt == 5'h00 && !cntWrite |=> forceReset)
    else $error("sequence gap not enforced");
  write_once_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && regWr && regAddr == wdc_pkg::ADDR_LIM_LOW && written[5] |=> $stable(pendLimit[7:0]))
    else $error("write-once register changed");
  closed_cfg_a: assert property (@(posedge mclk) disable iff (reset)
    clkEn && openCnt == 8'h00 && !(cntWrite) |=> $stable(ctrlOne) && $stable(limit))
    else $error("configuration changed while closed");
  no_update_a: assert property (@(posedge mclk) disable iff (reset)
    !ctrlOne[wdc_pkg::CTRL1_UPDATE_BIT] && openCnt == 8'h00 |=> openCnt == 8'h00)
    else $error("locked configuration reopened");
endmodule : wdc_watchdog
`default_nettype wire

// >>> wdc_watchdog_test.sv
// Testbench: register-level checks of the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module wdc_watchdog_test;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic lowPowerOsc1khz = 1'b0;
  logic int32kClk = 1'b0;
  logic extClk = 1'b0;
  logic forceReset;
  logic configOpen;
  logic resetSeen = 1'b0;
  int errors = 0;
  int checksDone = 0;
  logic [7:0] rv;
  logic [15:0] ca;
  logic [15:0] cb;
  logic [7:0] resetVal [6] = '{8'h80, 8'h01, 8'h00, 8'h04, 8'h00, 8'h00};
  logic [2:0] resetAddr [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  int srcRate [4] = '{204, 10, 20, 34};

  wdc_watchdog u_wdc_watchdog (.mclk(mclk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .lowPowerOsc1khz(lowPowerOsc1khz), .int32kClk(int32kClk), .extClk(extClk),
    .forceReset(forceReset), .configOpen(configOpen));

  // Bus clock and three free-running reference clocks
  always #20 mclk = ~mclk;
  always #400 lowPowerOsc1khz = ~lowPowerOsc1khz;
  always #200 int32kClk = ~int32kClk;
  always #120 extClk = ~extClk;

  // Sticky record of any forced reset
  always @(posedge mclk) begin
    if (forceReset === 1'b1) begin
      resetSeen <= 1'b1;
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : waitCyc

  task automatic doReset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    #1;
    resetSeen = 1'b0;
  endtask : doReset

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd

  task automatic word(input logic [15:0] w);
    wr(wdc_pkg::ADDR_CNT_HIGH, w[15:8]);
    wr(wdc_pkg::ADDR_CNT_LOW, w[7:0]);
  endtask : word

  task automatic rdCnt(output logic [15:0] c);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(wdc_pkg::ADDR_CNT_HIGH, hi);
    rd(wdc_pkg::ADDR_CNT_LOW, lo);
    c = {hi, lo};
  endtask : rdCnt

  task automatic refresh;
    word(wdc_pkg::REFRESH_FIRST);
    word(wdc_pkg::REFRESH_SECOND);
  endtask : refresh

  // Window registers are written only when window mode is requested
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [15:0] lim, input logic [15:0] early);
    wr(wdc_pkg::ADDR_CTRL_ONE, c1);
    wr(wdc_pkg::ADDR_CTRL_TWO, c2);
    wr(wdc_pkg::ADDR_LIM_HIGH, lim[15:8]);
    wr(wdc_pkg::ADDR_LIM_LOW, lim[7:0]);
    if (c2[wdc_pkg::CTRL2_WIN_BIT]) begin
      wr(wdc_pkg::ADDR_EARLY_HIGH, early[15:8]);
      wr(wdc_pkg::ADDR_EARLY_LOW, early[7:0]);
    end
    waitCyc(2);
  endtask : cfg

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end

  initial begin
    doReset();
    check(16'(configOpen), 16'h0001);
    for (int i = 0; i < 6; i++) begin
      rd(resetAddr[i], rv);
      check(16'(rv), 16'(resetVal[i]));
    end
    $display("test reset values done");

    cfg(8'hA0, 8'h00, 16'h0100, 16'h0000);
    check(16'(configOpen), 16'h0001);
    wr(wdc_pkg::ADDR_LIM_LOW, 8'h55);
    rd(wdc_pkg::ADDR_LIM_LOW, rv);
    check(16'(rv), 16'h0000);
    waitCyc(110);
    check(16'(configOpen), 16'h0000);
    rdCnt(ca);
    rdCnt(cb);
    check(16'(cb > ca), 16'h0001);
    check(16'(cb - ca), 16'h0004);
    refresh();
    rdCnt(ca);
    check(16'(ca < 16'h0010), 16'h0001);
    check(16'(resetSeen), 16'h0000);
    $display("test configure and refresh done");

    word(wdc_pkg::UNLOCK_FIRST);
    word(wdc_pkg::UNLOCK_SECOND);
    waitCyc(1);
    check(16'(configOpen), 16'h0001);
    cfg(8'hA0, 8'h00, 16'h0FFF, 16'h0000);
    rd(wdc_pkg::ADDR_LIM_LOW, rv);
    check(16'(rv), 16'h00FF);
    waitCyc(128);
    check(16'(configOpen), 16'h0000);
    waitCyc(200);
    rdCnt(ca);
    check(16'(ca > 16'h0100), 16'h0001);
    check(16'(resetSeen), 16'h0000);
    wr(wdc_pkg::ADDR_CNT_LOW, 8'h12);
    waitCyc(2);
    check(16'(resetSeen), 16'h0001);
    $display("test unlock and illegal write done");

    doReset();
    cfg(8'h80, 8'h00, 16'h0FFF, 16'h0000);
    check(16'(configOpen), 16'h0000);
    word(wdc_pkg::UNLOCK_FIRST);
    word(wdc_pkg::UNLOCK_SECOND);
    waitCyc(1);
    check(16'(configOpen), 16'h0000);
    doReset();
    cfg(8'h80, 8'h00, 16'h0FFF, 16'h0000);
    word(wdc_pkg::REFRESH_FIRST);
    waitCyc(20);
    word(wdc_pkg::REFRESH_SECOND);
    waitCyc(2);
    check(16'(resetSeen), 16'h0001);
    $display("test locked unlock and slow refresh done");

    doReset();
    cfg(8'h80, 8'h00, 16'h0040, 16'h0000);
    waitCyc(40);
    check(16'(resetSeen), 16'h0000);
    waitCyc(60);
    check(16'(resetSeen), 16'h0001);
    doReset();
    waitCyc(140);
    check(16'(configOpen), 16'h0000);
    check(16'(resetSeen), 16'h0001);
    wr(wdc_pkg::ADDR_CTRL_TWO, 8'h00);
    rd(wdc_pkg::ADDR_CTRL_TWO, rv);
    check(16'(rv), 16'h0001);
    $display("test timeout and defaults done");

    doReset();
    cfg(8'h80, 8'h80, 16'h0400, 16'h0100);
    refresh();
    waitCyc(2);
    check(16'(resetSeen), 16'h0001);
    doReset();
    cfg(8'h80, 8'h80, 16'h0400, 16'h0100);
    waitCyc(300);
    refresh();
    rdCnt(ca);
    check(16'(ca < 16'h0010), 16'h0001);
    check(16'(resetSeen), 16'h0000);
    rdCnt(ca);
    @(posedge mclk);
    clkEn <= 1'b0;
    repeat (50) @(posedge mclk);
    clkEn <= 1'b1;
    rdCnt(cb);
    check(16'((cb - ca) < 16'h0010), 16'h0001);
    $display("test window mode done");

    for (int s = 0; s < 4; s++) begin
      doReset();
      cfg(8'h80, 8'(s), 16'hFFFF, 16'h0000);
      rdCnt(ca);
      waitCyc(200);
      rdCnt(cb);
      check(16'((cb - ca) + 16'd3 >= srcRate[s] && (cb - ca) <= srcRate[s] + 3), 16'h0001);
    end
    doReset();
    cfg(8'h80, 8'h10, 16'hFFFF, 16'h0000);
    rdCnt(ca);
    waitCyc(1020);
    rdCnt(cb);
    check(16'((cb - ca) >= 16'd3 && (cb - ca) <= 16'd5), 16'h0001);
    $display("test clock sources done");
    results();
  end
endmodule : wdc_watchdog_test
`default_nettype wire
